/* logic/rsr_ctrl.sv */
// Reset source and stop recovery controller
`timescale 1ns/100ps
`default_nettype none
module rsr_ctrl #(
    parameter int GPIO_N = 8,
    parameter logic [7:0] STOP_FILTER_CYC = 8'h08
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire rsr_pkg::rsr_bus_req_t bus,
    output logic [7:0] rd_data,
    input wire logic stop_mode,
    input wire logic wdt_timeout,
    input wire logic timer_wake,
    input wire logic comp_wake,
    input wire logic ipo_tick,
    input wire logic [GPIO_N-1:0] gpio_in,
    input wire logic [GPIO_N-1:0] gpio_wake_en,
    input wire logic reset_pin_in,
    output logic reset_pin_out,
    output logic reset_pin_oe,
    input wire logic debug_pin_in,
    input wire logic debug_rst_req,
    input wire logic lv_below,
    output logic cpu_reset,
    output logic periph_reset,
    output logic vector_fetch,
    output logic [15:0] vector_addr,
    output logic osc_ipo_en,
    output logic osc_ipo_sel,
    output logic wdt_irq,
    output logic lv_irq,
    output logic port_capture_en,
    output logic [GPIO_N-1:0] port_input_data,
    output logic pin_irq
);
    initial begin
        if (GPIO_N < 1 || GPIO_N > 32 || STOP_FILTER_CYC < 8'h01) begin
            $error("rsr_ctrl: bad parameter");
        end
    end

    rsr_pkg::rsr_state_t state;
    rsr_pkg::rsr_state_t next_state;
    logic [1:0] pin_sync;
    logic [1:0] dbg_sync;
    logic [1:0] lv_sync;
    logic [GPIO_N-1:0] gp_s1;
    logic [GPIO_N-1:0] gp_s2;
    logic [GPIO_N-1:0] gp_prev;
    logic [7:0] low_cnt;
    logic [7:0] ipo_cnt;
    logic [3:0] flags;
    logic [7:0] pwr;
    logic [7:0] osc;
    logic [7:0] ctrl;
    logic lv_prev;
    logic wdt_pend;
    logic [3:0] next_flags;
    logic pin_low;
    logic ext_hit;
    logic wdt_rst;
    logic dbg_hit;
    logic gp_edge;
    logic wake;
    logic lv_flag;
    logic rel;

    // Async pins: only stage two is read
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_sync <= 2'h3;
            dbg_sync <= 2'h3;
            lv_sync <= 2'h0;
        end else begin
            pin_sync <= {pin_sync[0], reset_pin_in}; // see [RQ26]
            dbg_sync <= {dbg_sync[0], debug_pin_in};
            lv_sync <= {lv_sync[0], lv_below};
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            gp_s1 <= '0;
            gp_s2 <= '0;
            gp_prev <= '0;
        end else begin
            gp_s1 <= gpio_in;
            gp_s2 <= gp_s1;
            gp_prev <= gp_s2;
        end
    end

    assign pin_low = !pin_sync[1];

    // Low width counter, saturating
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            low_cnt <= 8'h00;
        end else if (!pin_low) begin
            low_cnt <= 8'h00;
        end else if (low_cnt != 8'hFF) begin
            low_cnt <= low_cnt + 8'h01;
        end
    end

    // Stop mode uses the longer glitch filter
    always_comb begin
        if (state == rsr_pkg::ST_STOP) begin
            ext_hit = pin_low && (low_cnt >= STOP_FILTER_CYC - 8'h01); // see [RQ20]
        end else begin
            ext_hit = pin_low && (low_cnt >= rsr_pkg::EXT_MIN_CYC - 8'h01); // see [RQ4]
        end
    end

    assign wdt_rst = wdt_timeout && ctrl[rsr_pkg::CTRL_WDT_SEL]; // see [RQ1]
    assign dbg_hit = ctrl[rsr_pkg::CTRL_DBG_RST]; // see [RQ9]
    assign gp_edge = |((gp_s2 ^ gp_prev) & gpio_wake_en); // see [RQ18]
    assign wake = wdt_timeout || timer_wake || comp_wake || gp_edge; // see [RQ15]
    assign rel = (ipo_cnt >= rsr_pkg::SYS_HOLD_IPO) && !pin_low;

    always_comb begin
        next_state = state;
        case (state)
            rsr_pkg::ST_RUN: begin
                if (ext_hit || wdt_rst || dbg_hit) begin
                    next_state = rsr_pkg::ST_SYSRST;
                end else if (stop_mode) begin
                    next_state = rsr_pkg::ST_STOP;
                end
            end
            rsr_pkg::ST_STOP: begin
                if (ext_hit || !dbg_sync[1] || dbg_hit) begin
                    next_state = rsr_pkg::ST_SYSRST; // see [RQ16]
                end else if (wake) begin
                    next_state = rsr_pkg::ST_RECOV;
                end
            end
            rsr_pkg::ST_RECOV: begin
                if (ext_hit || dbg_hit) begin
                    next_state = rsr_pkg::ST_SYSRST;
                end else if (ipo_cnt >= rsr_pkg::RECOV_IPO) begin
                    next_state = rsr_pkg::ST_RUN; // see [RQ11]
                end
            end
            rsr_pkg::ST_SYSRST: begin
                if (rel) begin
                    next_state = rsr_pkg::ST_RUN; // see [RQ5] see [RQ23]
                end
            end
            default: next_state = rsr_pkg::ST_SYSRST;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= rsr_pkg::ST_SYSRST;
        end else begin
            state <= next_state;
        end
    end

    // Oscillator cycles since entering a hold state
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ipo_cnt <= 8'h00;
        end else if (next_state != state) begin
            ipo_cnt <= 8'h00;
        end else if (ipo_tick && ipo_cnt != 8'hFF) begin
            ipo_cnt <= ipo_cnt + 8'h01;
        end
    end

    // Cause flags; an event beats a same-cycle read clear
    always_comb begin
        next_flags = flags;
        if (bus.rd && bus.addr == rsr_pkg::CAUSE_ADDR) begin
            next_flags = 4'h0; // see [RQ24]
        end
        if (next_state == rsr_pkg::ST_SYSRST && state != rsr_pkg::ST_SYSRST) begin
            if (ext_hit) begin
                next_flags = rsr_pkg::FLAGS_EXT; // see [RQ6]
            end else if (wdt_rst && state == rsr_pkg::ST_RUN) begin
                next_flags = rsr_pkg::FLAGS_WDT; // see [RQ3]
            end else begin
                next_flags = rsr_pkg::FLAGS_POR; // see [RQ10]
            end
        end else if (next_state == rsr_pkg::ST_RECOV && state == rsr_pkg::ST_STOP) begin
            if (wdt_timeout) begin
                next_flags = rsr_pkg::FLAGS_STOP_WDT; // see [RQ17]
            end else begin
                next_flags = rsr_pkg::FLAGS_STOP; // see [RQ14]
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags <= rsr_pkg::FLAGS_POR;
        end else begin
            flags <= next_flags;
        end
    end

    // Control: watchdog select, debug request, pin drive
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= rsr_pkg::CTRL_RST;
        end else begin
            if (bus.wr && bus.addr == rsr_pkg::CTRL_ADDR) begin
                ctrl <= {5'h00, bus.wdata[2:0]};
            end else if (state == rsr_pkg::ST_SYSRST) begin
                ctrl[rsr_pkg::CTRL_DBG_RST] <= 1'b0; // see [RQ9]
            end
            if (debug_rst_req) begin
                ctrl[rsr_pkg::CTRL_DBG_RST] <= 1'b1;
            end
        end
    end

    // Detector enable survives recovery
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwr <= rsr_pkg::PWR_RST;
        end else if (bus.wr && bus.addr == rsr_pkg::PWR_ADDR) begin
            pwr <= {3'h0, bus.wdata[4], 4'h0}; // see [RQ22]
        end
    end

    // Reset or recovery always lands on the precise oscillator
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            osc <= rsr_pkg::OSC_RST;
        end else if (state == rsr_pkg::ST_RECOV || state == rsr_pkg::ST_SYSRST) begin
            osc <= rsr_pkg::OSC_RST; // see [RQ12]
        end else if (bus.wr && bus.addr == rsr_pkg::OSC_ADDR) begin
            osc <= {6'h00, bus.wdata[1:0]};
        end
    end

    assign lv_flag = pwr[rsr_pkg::PWR_LV_EN] && lv_sync[1]; // see [RQ21]

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= 8'h00;
        end else if (bus.rd) begin
            case (bus.addr)
                rsr_pkg::CAUSE_ADDR: rd_data <= {flags, 3'h0, lv_flag}; // see [RQ25]
                rsr_pkg::PWR_ADDR: rd_data <= pwr;
                rsr_pkg::OSC_ADDR: rd_data <= osc;
                rsr_pkg::CTRL_ADDR: rd_data <= ctrl;
                default: rd_data <= 8'h00;
            endcase
        end else begin
            rd_data <= 8'h00;
        end
    end

    // Watchdog interrupt from stop is held until the processor runs; low-voltage edge is not held
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wdt_pend <= 1'b0;
            wdt_irq <= 1'b0;
            lv_prev <= 1'b0;
            lv_irq <= 1'b0;
        end else begin
            wdt_irq <= 1'b0;
            if (state == rsr_pkg::ST_SYSRST) begin
                wdt_pend <= 1'b0;
            end else if (wdt_timeout && !ctrl[rsr_pkg::CTRL_WDT_SEL]) begin
                wdt_pend <= 1'b1; // see [RQ2]
            end else if (state == rsr_pkg::ST_RUN && wdt_pend) begin
                wdt_pend <= 1'b0;
                wdt_irq <= 1'b1; // see [RQ15]
            end
            lv_prev <= lv_flag;
            lv_irq <= lv_flag && !lv_prev; // see [RQ22]
        end
    end

    // Port data frozen outside run; level sampled at recovery end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            port_input_data <= '0;
            pin_irq <= 1'b0;
        end else begin
            pin_irq <= 1'b0;
            if (state == rsr_pkg::ST_RUN) begin
                port_input_data <= gp_s2; // see [RQ19]
                pin_irq <= |((gp_s2 ^ port_input_data) & gpio_wake_en);
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            vector_fetch <= 1'b0;
        end else begin
            vector_fetch <= next_state == rsr_pkg::ST_RUN && state != rsr_pkg::ST_RUN
                && state != rsr_pkg::ST_STOP; // see [RQ13]
        end
    end

    assign vector_addr = rsr_pkg::RESET_VECTOR_ADDR;
    assign reset_pin_out = 1'b0;
    // Own drive ends with the hold unless CTRL_PIN_DRV is set; a drive past it keeps us in reset via the synced pin
    assign reset_pin_oe = (state == rsr_pkg::ST_SYSRST && ipo_cnt < rsr_pkg::SYS_HOLD_IPO)
        || ctrl[rsr_pkg::CTRL_PIN_DRV]; // see [RQ7] see [RQ8]
    assign cpu_reset = state == rsr_pkg::ST_SYSRST || state == rsr_pkg::ST_RECOV;
    assign periph_reset = state == rsr_pkg::ST_SYSRST;
    assign osc_ipo_en = osc[rsr_pkg::OSC_IPO_EN];
    assign osc_ipo_sel = osc[rsr_pkg::OSC_IPO_SEL];
    assign port_capture_en = state == rsr_pkg::ST_RUN;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_wdt_reset_entry: assert property (state == rsr_pkg::ST_RUN && wdt_timeout && ctrl[0] |=> state == rsr_pkg::ST_SYSRST) else $error("watchdog reset missed"); // see [RQ1]
    a_wdt_irq_mode: assert property (state == rsr_pkg::ST_RUN && wdt_timeout && !ctrl[0] && !ext_hit && !dbg_hit |=> state != rsr_pkg::ST_SYSRST ##1 wdt_irq) else $error("watchdog irq wrong"); // see [RQ2]
    a_wdt_flag_set: assert property (state == rsr_pkg::ST_RUN && wdt_rst && !ext_hit |=> flags == 4'h2) else $error("watchdog flag wrong"); // see [RQ3]
    a_pin_four_low: assert property (state == rsr_pkg::ST_RUN && !stop_mode && pin_low ##1 pin_low [*3] |-> state == rsr_pkg::ST_SYSRST || next_state == rsr_pkg::ST_SYSRST) else $error("pin reset missed"); // see [RQ4]
    a_hold_pin_low: assert property (state == rsr_pkg::ST_SYSRST && pin_low |=> state == rsr_pkg::ST_SYSRST) else $error("left reset with pin low"); // see [RQ5]
    a_ext_flag_set: assert property (state == rsr_pkg::ST_RUN && ext_hit |=> flags == 4'h1) else $error("external flag wrong"); // see [RQ6]
    a_pin_drive: assert property (state == rsr_pkg::ST_SYSRST && ipo_cnt < rsr_pkg::SYS_HOLD_IPO |-> reset_pin_oe && !reset_pin_out) else $error("pin not driven"); // see [RQ8]
    a_dbg_clear: assert property (state == rsr_pkg::ST_SYSRST && !debug_rst_req && !(bus.wr && bus.addr == rsr_pkg::CTRL_ADDR) |=> !ctrl[1]) else $error("debug bit stuck"); // see [RQ9]
    a_recov_len: assert property (state == rsr_pkg::ST_RECOV && ipo_cnt >= rsr_pkg::RECOV_IPO && !ext_hit && !dbg_hit |=> state == rsr_pkg::ST_RUN || state == rsr_pkg::ST_STOP) else $error("recovery length wrong"); // see [RQ11]
    a_sys_hold: assert property (state == rsr_pkg::ST_SYSRST && ipo_cnt < 8'h44 |=> state == rsr_pkg::ST_SYSRST) else $error("reset released early"); // see [RQ23]
    a_read_clear: assert property (bus.rd && bus.addr == rsr_pkg::CAUSE_ADDR && next_state == state |=> flags == 4'h0) else $error("read did not clear"); // see [RQ24]
    a_stop_flag: assert property (state == rsr_pkg::ST_STOP && next_state == rsr_pkg::ST_RECOV |=> flags[2]) else $error("stop flag missing"); // see [RQ14]
    a_osc_restore: assert property (state == rsr_pkg::ST_RECOV |=> osc == 8'h03) else $error("oscillator not restored"); // see [RQ12]
    a_lv_live: assert property (pwr[4] && !lv_sync[1] |-> !lv_flag) else $error("low voltage latched"); // see [RQ21]

    c_wdt_reset: cover property (state == rsr_pkg::ST_RUN ##1 state == rsr_pkg::ST_SYSRST && flags == 4'h2);
    c_gpio_recov: cover property (state == rsr_pkg::ST_STOP && gp_edge ##1 state == rsr_pkg::ST_RECOV);
    c_stop_pin_rst: cover property (state == rsr_pkg::ST_STOP ##1 state == rsr_pkg::ST_SYSRST && flags == 4'h1);
    c_wdt_irq: cover property (wdt_irq);
endmodule : rsr_ctrl
`default_nettype wire

/* logic/rsr_pkg.sv */
// Constants and types for the reset source and stop recovery block
// Behaviour
// [RQ1] Watchdog time-out resets when select is 1
// [RQ2] Watchdog time-out interrupts when select is 0
// [RQ3] Watchdog reset sets watchdog cause flag
// [RQ4] Four-cycle low reset pin always resets; in stop mode the code waits STOP_FILTER_CYC cycles instead
// [RQ5] Stay in reset while pin low
// [RQ6] Pin reset sets external cause flag
// [RQ7] Pin drives low during reset or enable
// [RQ8] Internal reset drives pin until delay ends
// [RQ9] Debug request resets chip, bit self-clears
// [RQ10] Debug reset sets power-on cause flag
// [RQ11] Recovery holds processor four oscillator cycles
// [RQ12] Recovery touches only cause and oscillator
// [RQ13] Processor fetches vector at 0002h/0003h
// [RQ14] Every recovery sets stop cause flag
// [RQ15] Stop wake interrupts cause recovery, then service
// [RQ16] Stop pin or debug low resets
// [RQ17] Stop watchdog sets watchdog and stop flags
// [RQ18] Enabled GPIO edge starts recovery
// [RQ19] Port capture only if level persists
// [RQ20] Stop glitch filter ignores short pulses
// [RQ21] Low-voltage flag is live, not latched
// [RQ22] Power control bit 4 enables detector
// [RQ23] System reset holds 68 oscillator cycles
// [RQ24] Cause register read clears upper flags
// [RQ25] Cause register at FF0h, fixed bits
// [RQ26] Reset pin synchronised by two flops
package rsr_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam logic [11:0] CAUSE_ADDR = 12'hFF0;
    localparam logic [11:0] PWR_ADDR = 12'hFF4;
    localparam logic [11:0] OSC_ADDR = 12'hFF8;
    localparam logic [11:0] CTRL_ADDR = 12'hFFC;
    localparam int CAUSE_POR = 7;
    localparam int CAUSE_STOP = 6;
    localparam int CAUSE_WDT = 5;
    localparam int CAUSE_EXT = 4;
    localparam int CAUSE_LV = 0;
    localparam int PWR_LV_EN = 4;
    localparam int OSC_IPO_EN = 0;
    localparam int OSC_IPO_SEL = 1;
    localparam int CTRL_WDT_SEL = 0;
    localparam int CTRL_DBG_RST = 1;
    localparam int CTRL_PIN_DRV = 2;
    localparam logic [3:0] FLAGS_EXT = 4'h1;
    localparam logic [3:0] FLAGS_WDT = 4'h2;
    localparam logic [3:0] FLAGS_POR = 4'h8;
    localparam logic [3:0] FLAGS_STOP = 4'h4;
    localparam logic [3:0] FLAGS_STOP_WDT = 4'h6;
    localparam logic [7:0] PWR_RST = 8'h00;
    localparam logic [7:0] OSC_RST = 8'h03;
    localparam logic [7:0] CTRL_RST = 8'h01;
    localparam logic [7:0] SYS_HOLD_IPO = 8'h44;
    localparam logic [7:0] RECOV_IPO = 8'h04;
    localparam logic [7:0] EXT_MIN_CYC = 8'h04;
    localparam logic [15:0] RESET_VECTOR_ADDR = 16'h0002;
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_STOP = 2'b01,
        ST_RECOV = 2'b10,
        ST_SYSRST = 2'b11
    } rsr_state_t;
    typedef struct packed {
        logic [11:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } rsr_bus_req_t;
endpackage : rsr_pkg

/* tb/reset_source_and_stop_recovery_test.sv */
// Self-checking bench for the reset source and stop recovery block
`timescale 1ns/100ps
`default_nettype none
module reset_source_and_stop_recovery_test;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    rsr_pkg::rsr_bus_req_t bus = '0;
    logic stop_mode = 1'b0;
    logic wdt_timeout = 1'b0;
    logic timer_wake = 1'b0;
    logic comp_wake = 1'b0;
    logic ipo_tick = 1'b0;
    logic debug_rst_req = 1'b0;
    logic debug_pin_in = 1'b1;
    logic lv_below = 1'b0;
    logic hold_low = 1'b0;
    logic [7:0] gpio_in = 8'h00;
    logic [7:0] gpio_wake_en = 8'h00;
    logic reset_pin_in;
    logic [7:0] rd_data;
    logic reset_pin_out;
    logic reset_pin_oe;
    logic cpu_reset;
    logic periph_reset;
    logic vector_fetch;
    logic [15:0] vector_addr;
    logic osc_ipo_en;
    logic osc_ipo_sel;
    logic wdt_irq;
    logic lv_irq;
    logic port_capture_en;
    logic [7:0] port_input_data;
    logic pin_irq;
    logic rd_q = 1'b0;
    logic [7:0] expq[$];
    int failures = 0;
    int compares = 0;
    int ticks = 0;
    int tcnt = 0;
    int wdt_n = 0;
    int lv_n = 0;
    int vf_n = 0;
    int pin = 0;
    int k;

    always #2 core_clk = ~core_clk;

    rsr_ctrl dut (.core_clk(core_clk), .rst_n(rst_n), .bus(bus), .rd_data(rd_data),
        .stop_mode(stop_mode), .wdt_timeout(wdt_timeout), .timer_wake(timer_wake),
        .comp_wake(comp_wake), .ipo_tick(ipo_tick), .gpio_in(gpio_in),
        .gpio_wake_en(gpio_wake_en), .reset_pin_in(reset_pin_in),
        .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
        .debug_pin_in(debug_pin_in), .debug_rst_req(debug_rst_req), .lv_below(lv_below),
        .cpu_reset(cpu_reset), .periph_reset(periph_reset), .vector_fetch(vector_fetch),
        .vector_addr(vector_addr), .osc_ipo_en(osc_ipo_en), .osc_ipo_sel(osc_ipo_sel),
        .wdt_irq(wdt_irq), .lv_irq(lv_irq), .port_capture_en(port_capture_en),
        .port_input_data(port_input_data), .pin_irq(pin_irq));

    rsr_board board (.dev_oe(reset_pin_oe), .dev_out(reset_pin_out), .hold_low(hold_low),
        .line(reset_pin_in));

    // Oscillator tick every 5 cycles, wider than the pin sync latency at reset exit
    always @(posedge core_clk) begin
        tcnt <= (tcnt == 4) ? 0 : tcnt + 1;
        ipo_tick <= (tcnt == 4);
    end

    always @(posedge core_clk) begin
        if (cpu_reset === 1'b1 && ipo_tick === 1'b1) ticks++;
        if (wdt_irq === 1'b1) wdt_n++;
        if (lv_irq === 1'b1) lv_n++;
        if (vector_fetch === 1'b1) vf_n++;
        rd_q <= bus.rd;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    // Read data stand only in the cycle after the strobe
    always @(negedge core_clk) begin
        if (rd_q === 1'b1) chk({8'h00, rd_data}, {8'h00, expq.pop_front()});
    end

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus <= '0;
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge core_clk);
        expq.push_back(e);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus <= '0;
    endtask : rd

    task automatic wait_hi;
        int i;
        for (i = 0; i < 60 && cpu_reset !== 1'b1; i++) @(negedge core_clk);
        chk(16'(cpu_reset), 16'h0001);
    endtask : wait_hi

    task automatic wait_run(input int n);
        int i;
        int v;
        v = vf_n;
        for (i = 0; i < 3000 && cpu_reset !== 1'b0; i++) @(negedge core_clk);
        repeat (3) @(negedge core_clk);
        chk(16'(vf_n - v), 16'h0001);
        chk(vector_addr, 16'h0002);
        if (n > 0) chk(16'(ticks), 16'(n));
    endtask : wait_run

    task automatic stop_wake(input int w, input logic [7:0] cause);
        wr(rsr_pkg::OSC_ADDR, 8'h00);
        @(posedge core_clk);
        stop_mode <= 1'b1;
        repeat (3) @(negedge core_clk);
        chk(16'(port_capture_en), 16'h0000);
        ticks = 0;
        @(posedge core_clk);
        case (w)
            0: wdt_timeout <= 1'b1;
            1: timer_wake <= 1'b1;
            2: comp_wake <= 1'b1;
            default: gpio_in[pin] <= ~gpio_in[pin];
        endcase
        @(posedge core_clk);
        {wdt_timeout, timer_wake, comp_wake} <= 3'h0;
        wait_hi;
        chk(16'(periph_reset), 16'h0000);
        @(posedge core_clk);
        stop_mode <= 1'b0;
        wait_run(4);
        chk({14'h0000, osc_ipo_sel, osc_ipo_en}, 16'h0003);
        rd(rsr_pkg::CAUSE_ADDR, cause);
        rd(rsr_pkg::OSC_ADDR, 8'h03);
    endtask : stop_wake

    task automatic close_out;
        $display("Comparisons %0d, failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : close_out

    initial begin
        #200000;
        failures++;
        close_out;
    end

    initial begin
        void'($urandom(727));
        pin = $urandom % 8;
        gpio_in = 8'($urandom);
        gpio_wake_en = 8'h01 << pin;
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        wait_run(0);
        rd(rsr_pkg::CAUSE_ADDR, 8'h80);
        rd(rsr_pkg::CAUSE_ADDR, 8'h00);
        rd(rsr_pkg::CTRL_ADDR, 8'h01);
        rd(rsr_pkg::OSC_ADDR, 8'h03);
        rd(rsr_pkg::PWR_ADDR, 8'h00);
        rd(12'h123, 8'h00);
        // Watchdog in reset mode
        @(negedge core_clk) ticks = 0;
        @(posedge core_clk) wdt_timeout <= 1'b1;
        @(posedge core_clk) wdt_timeout <= 1'b0;
        wait_hi;
        chk(16'(reset_pin_oe), 16'h0001);
        wait_run(68);
        rd(rsr_pkg::CAUSE_ADDR, 8'h20);
        // Watchdog in interrupt mode
        wr(rsr_pkg::CTRL_ADDR, 8'h00);
        @(posedge core_clk) wdt_timeout <= 1'b1;
        @(posedge core_clk) wdt_timeout <= 1'b0;
        repeat (8) @(negedge core_clk);
        chk(16'(wdt_n), 16'h0001);
        chk(16'(cpu_reset), 16'h0000);
        // Two-cycle glitch is too short, four cycles resets outside stop mode
        @(posedge core_clk) hold_low <= 1'b1;
        repeat (2) @(posedge core_clk);
        hold_low <= 1'b0;
        repeat (10) @(negedge core_clk);
        chk(16'(cpu_reset), 16'h0000);
        @(posedge core_clk) hold_low <= 1'b1;
        repeat (4) @(posedge core_clk);
        hold_low <= 1'b0;
        wait_hi;
        wait_run(0);
        rd(rsr_pkg::CAUSE_ADDR, 8'h10);
        // Pin held well past the reset time-out
        @(posedge core_clk) hold_low <= 1'b1;
        repeat (500) @(negedge core_clk);
        chk(16'(cpu_reset), 16'h0001);
        @(posedge core_clk) hold_low <= 1'b0;
        wait_run(0);
        rd(rsr_pkg::CAUSE_ADDR, 8'h10);
        // Debugger request
        @(posedge core_clk) debug_rst_req <= 1'b1;
        @(posedge core_clk) debug_rst_req <= 1'b0;
        wait_hi;
        chk(16'(periph_reset), 16'h0001);
        wait_run(0);
        rd(rsr_pkg::CAUSE_ADDR, 8'h80);
        rd(rsr_pkg::CTRL_ADDR, 8'h00);
        // Stop recoveries from every wake source
        wr(rsr_pkg::PWR_ADDR, 8'h10);
        for (k = 0; k < 4; k++) stop_wake(k, (k == 0) ? 8'h60 : 8'h40);
        rd(rsr_pkg::PWR_ADDR, 8'h10);
        chk(16'(port_input_data[pin]), 16'(gpio_in[pin]));
        // Stop mode: glitch ignored, long low resets
        @(posedge core_clk) stop_mode <= 1'b1;
        hold_low <= 1'b1;
        repeat (3) @(posedge core_clk);
        hold_low <= 1'b0;
        repeat (12) @(negedge core_clk);
        chk(16'(cpu_reset), 16'h0000);
        @(posedge core_clk) hold_low <= 1'b1;
        wait_hi;
        @(posedge core_clk) stop_mode <= 1'b0;
        hold_low <= 1'b0;
        wait_run(0);
        rd(rsr_pkg::CAUSE_ADDR, 8'h10);
        @(posedge core_clk) stop_mode <= 1'b1;
        debug_pin_in <= 1'b0;
        wait_hi;
        @(posedge core_clk) stop_mode <= 1'b0;
        debug_pin_in <= 1'b1;
        wait_run(0);
        rd(rsr_pkg::CAUSE_ADDR, 8'h80);
        // Live low-voltage flag, gated by the detector enable
        wr(rsr_pkg::PWR_ADDR, 8'h10);
        @(posedge core_clk) lv_below <= 1'b1;
        repeat (6) @(negedge core_clk);
        rd(rsr_pkg::CAUSE_ADDR, 8'h01);
        rd(rsr_pkg::CAUSE_ADDR, 8'h01);
        chk(16'(lv_n), 16'h0001);
        @(posedge core_clk) lv_below <= 1'b0;
        repeat (6) @(negedge core_clk);
        rd(rsr_pkg::CAUSE_ADDR, 8'h00);
        wr(rsr_pkg::PWR_ADDR, 8'h00);
        @(posedge core_clk) lv_below <= 1'b1;
        repeat (6) @(negedge core_clk);
        rd(rsr_pkg::CAUSE_ADDR, 8'h00);
        repeat (4) @(negedge core_clk);
        close_out;
    end
endmodule : reset_source_and_stop_recovery_test
`default_nettype wire

/* tb/rsr_board.sv */
// Board side of the shared reset line: pull-up plus other parties sinking it
`timescale 1ns/100ps
`default_nettype none
module rsr_board (
    input wire logic dev_oe,
    input wire logic dev_out,
    input wire logic hold_low,
    output logic line
);
    // Wired-AND with a pull-up, so a released line reads high, never the last value
    assign line = ~((dev_oe & ~dev_out) | hold_low);
endmodule : rsr_board
`default_nettype wire
